/* rtl/ufs_consts.vh */
`ifndef UFS_CONSTS_VH
`define UFS_CONSTS_VH

// ==========================================================
// register byte offsets
`define UFS_OFS_CONTROL      8'h00
`define UFS_OFS_IRQ_ENABLE   8'h04
`define UFS_OFS_FIFO_FLUSH   8'h08
`define UFS_OFS_LINE_STATUS  8'h0C
`define UFS_OFS_MODEM_STATUS 8'h10
`define UFS_OFS_IRQ_IDENT    8'h14
`define UFS_OFS_FIFO_LEVEL   8'h18

// ==========================================================
// control register fields
`define UFS_CTL_FOUR_WIRE    0
`define UFS_CTL_AUTO_REQ     1
`define UFS_CTL_AUTO_CLEAR   2
`define UFS_CTL_POLARITY     3
`define UFS_CTL_LEVEL_LO     4
`define UFS_CTL_LEVEL_HI     5
`define UFS_CTL_MANUAL_REQ   6
`define UFS_CTL_BREAK        7
`define UFS_CTL_RESET        8'h00

// ==========================================================
// interrupt enable fields
`define UFS_IEN_RX_DATA      0
`define UFS_IEN_TX_EMPTY     1
`define UFS_IEN_LINE         2
`define UFS_IEN_MODEM        3
`define UFS_IEN_TRIG_LO      4
`define UFS_IEN_TRIG_HI      5
`define UFS_IEN_RESET        6'h00

// ==========================================================
// flush fields
`define UFS_FLUSH_TX         0
`define UFS_FLUSH_RX         1

// ==========================================================
// line status fields
`define UFS_LS_DATA          0
`define UFS_LS_OVERRUN       1
`define UFS_LS_PARITY        2
`define UFS_LS_FRAMING       3
`define UFS_LS_BREAK         4
`define UFS_LS_TX_EMPTY      5
`define UFS_LS_SHIFT_EMPTY   6
`define UFS_LS_ERROR         7

// ==========================================================
// modem status fields
`define UFS_MS_CHANGED       0
`define UFS_MS_LEVEL         4

// ==========================================================
// interrupt identity codes
`define UFS_IRQ_LINE         3'h3
`define UFS_IRQ_RX_DATA      3'h2
`define UFS_IRQ_RX_IDLE      3'h6
`define UFS_IRQ_TX_EMPTY     3'h1
`define UFS_IRQ_MODEM        3'h0

// ==========================================================
// fifo depth and receive idle timeout in character times
`define UFS_FIFO_DEPTH       5'h10
`define UFS_IDLE_CHARS       3'h4

`endif

/* rtl/ufs_top.v */
`timescale 1ns/10ps
`include "ufs_consts.vh"

module ufs_top (
	input  wire        clock_in,
	input  wire        reset_n_in,
	// ahb-lite slave
	input  wire        hsel_in,
	input  wire [31:0] haddr_in,
	input  wire [1:0]  htrans_in,
	input  wire        hwrite_in,
	input  wire [2:0]  hsize_in,
	input  wire [31:0] hwdata_in,
	input  wire        hready_in,
	output wire        hreadyout_out,
	output wire        hresp_out,
	output reg  [31:0] hrdata_out,
	// serial datapath status, same clock
	input  wire [4:0]  rx_fifo_count_in,
	input  wire [4:0]  tx_fifo_count_in,
	input  wire        tx_shifter_busy_in,
	input  wire        rx_char_done_in,
	input  wire        rx_parity_err_in,
	input  wire        rx_frame_err_in,
	input  wire        rx_break_in,
	input  wire        rx_char_time_in,
	// serial datapath control
	output wire        tx_start_allow_out,
	output reg         tx_break_out,
	output reg         tx_fifo_flush_out,
	output reg         rx_fifo_flush_out,
	// handshake pins
	input  wire        clear_to_send_pin_in,
	output reg         request_to_send_out,
	output reg         request_to_send_oe_out
);

	// ==========================================================
	// functions
	function [4:0] deassert_level;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    deassert_level = 5'h08;
				2'h1:    deassert_level = 5'h0B;
				2'h2:    deassert_level = 5'h0D;
				default: deassert_level = 5'h0F;
			endcase
		end
	endfunction

	function [4:0] data_trigger;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    data_trigger = 5'h01;
				2'h1:    data_trigger = 5'h04;
				2'h2:    data_trigger = 5'h08;
				default: data_trigger = 5'h0E;
			endcase
		end
	endfunction

	// ==========================================================
	// registers and wires
	reg  [7:0]  control_r;
	reg  [5:0]  irq_enable_r;
	reg         cts_meta_r;
	reg         cts_sync_r;
	reg         cts_last_r;
	reg         cts_changed_r;
	reg         overrun_r;
	reg         parity_r;
	reg         framing_r;
	reg         break_seen_r;
	reg         error_sum_r;
	reg  [2:0]  idle_count_r;
	reg         dp_valid_r;
	reg         dp_write_r;
	reg  [7:0]  dp_addr_r;
	reg  [31:0] rdata_nxt;
	reg  [3:0]  irq_ident_nxt;

	wire        four_wire;
	wire        auto_request_enable;
	wire        auto_clear_gate_enable;
	wire        handshake_polarity;
	wire        line_break_request;
	wire [4:0]  request_deassert_level;
	wire [4:0]  rx_trigger;
	wire        addr_phase;
	wire        wr_control;
	wire        wr_irq_enable;
	wire        wr_flush;
	wire        rd_line_status;
	wire        rd_modem_status;
	wire        transmit_fifo_flush;
	wire        receive_fifo_flush;
	wire        clear_active;
	wire        request_active;
	wire        rx_full;
	wire        tx_fifo_empty_flag;
	wire        shifter_empty_flag;
	wire        rx_data_present_flag;
	wire        line_irq;
	wire        rx_data_irq;
	wire        rx_idle_irq;
	wire        tx_empty_irq;
	wire        modem_irq;
	wire [7:0]  line_status;
	wire [7:0]  modem_status;

	assign four_wire              = control_r[`UFS_CTL_FOUR_WIRE];
	assign auto_request_enable    = control_r[`UFS_CTL_AUTO_REQ];
	assign auto_clear_gate_enable = control_r[`UFS_CTL_AUTO_CLEAR];
	assign handshake_polarity     = control_r[`UFS_CTL_POLARITY];
	assign line_break_request     = control_r[`UFS_CTL_BREAK];
	assign request_deassert_level =
		deassert_level(control_r[`UFS_CTL_LEVEL_HI:`UFS_CTL_LEVEL_LO]);
	assign rx_trigger = data_trigger(irq_enable_r[`UFS_IEN_TRIG_HI:`UFS_IEN_TRIG_LO]);

	// ==========================================================
	// ahb-lite slave, zero wait, always okay
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	// only whole-word accesses are acted upon
	assign addr_phase = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'h2);

	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r  <= 8'h00;
		end else begin
			dp_valid_r <= addr_phase & hwrite_in;
			dp_write_r <= hwrite_in;
			dp_addr_r  <= haddr_in[7:0];
		end
	end

	// writes land in the data phase; reads are sampled in the address phase
	assign wr_control      = dp_valid_r & dp_write_r & (dp_addr_r == `UFS_OFS_CONTROL);
	assign wr_irq_enable   = dp_valid_r & dp_write_r & (dp_addr_r == `UFS_OFS_IRQ_ENABLE);
	assign wr_flush        = dp_valid_r & dp_write_r & (dp_addr_r == `UFS_OFS_FIFO_FLUSH);
	assign rd_line_status  = addr_phase & ~hwrite_in & (haddr_in[7:0] == `UFS_OFS_LINE_STATUS);
	assign rd_modem_status = addr_phase & ~hwrite_in & (haddr_in[7:0] == `UFS_OFS_MODEM_STATUS);

	assign transmit_fifo_flush = wr_flush & hwdata_in[`UFS_FLUSH_TX];
	assign receive_fifo_flush  = wr_flush & hwdata_in[`UFS_FLUSH_RX];

	// ==========================================================
	// control and enable registers
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			control_r    <= `UFS_CTL_RESET;
			irq_enable_r <= `UFS_IEN_RESET;
		end else begin
			if (wr_control) begin
				control_r <= hwdata_in[7:0];
			end
			if (wr_flush && (hwdata_in[`UFS_FLUSH_TX] || hwdata_in[`UFS_FLUSH_RX])) begin
				// trigger back to one character, enables kept
				irq_enable_r[`UFS_IEN_TRIG_HI:`UFS_IEN_TRIG_LO] <= 2'h0;
			end else if (wr_irq_enable) begin
				irq_enable_r <= hwdata_in[5:0];
			end
		end
	end

	// flush pulses only reach the fifos, never the shift registers
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_fifo_flush_out <= 1'b0;
			rx_fifo_flush_out <= 1'b0;
		end else begin
			tx_fifo_flush_out <= transmit_fifo_flush;
			rx_fifo_flush_out <= receive_fifo_flush;
		end
	end

	// ==========================================================
	// clear-to-send synchroniser and change flag
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			// idle level of the active-low default, so no false change after reset
			cts_meta_r    <= 1'b1;
			cts_sync_r    <= 1'b1;
			cts_last_r    <= 1'b1;
			cts_changed_r <= 1'b0;
		end else begin
			cts_meta_r <= clear_to_send_pin_in;
			cts_sync_r <= cts_meta_r;
			cts_last_r <= cts_sync_r;
			// edge wins over the read that clears it
			cts_changed_r <= (cts_changed_r & ~rd_modem_status) |
				(cts_sync_r ^ cts_last_r);
		end
	end

	// ==========================================================
	// handshake lines
	assign clear_active = handshake_polarity ? cts_sync_r : ~cts_sync_r;
	assign request_active = rx_fifo_count_in < request_deassert_level;

	// start gate only: a character already in the shifter finishes
	assign tx_start_allow_out = ~line_break_request &
		(~(four_wire & auto_clear_gate_enable) | clear_active);

	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			request_to_send_out    <= 1'b0;
			request_to_send_oe_out <= 1'b0;
			tx_break_out           <= 1'b0;
		end else begin
			request_to_send_oe_out <= four_wire;
			if (auto_request_enable) begin
				request_to_send_out <= handshake_polarity ? request_active
					: ~request_active;
			end else begin
				request_to_send_out <= control_r[`UFS_CTL_MANUAL_REQ];
			end
			// forces the line low mid-character, corrupting it
			tx_break_out <= line_break_request;
		end
	end

	// ==========================================================
	// line status flags, event wins over read clear
	assign rx_full = rx_fifo_count_in == `UFS_FIFO_DEPTH;

	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			overrun_r    <= 1'b0;
			parity_r     <= 1'b0;
			framing_r    <= 1'b0;
			break_seen_r <= 1'b0;
			error_sum_r  <= 1'b0;
		end else begin
			overrun_r    <= (overrun_r & ~rd_line_status) |
				(rx_char_done_in & rx_full);
			parity_r     <= (parity_r & ~rd_line_status) | rx_parity_err_in;
			framing_r    <= (framing_r & ~rd_line_status) | rx_frame_err_in;
			break_seen_r <= (break_seen_r & ~rd_line_status) | rx_break_in;
			error_sum_r  <= (error_sum_r & ~rd_line_status) |
				rx_parity_err_in | rx_frame_err_in | rx_break_in;
		end
	end

	assign tx_fifo_empty_flag   = tx_fifo_count_in == 5'h00;
	assign shifter_empty_flag   = ~tx_shifter_busy_in;
	assign rx_data_present_flag = rx_fifo_count_in != 5'h00;

	assign line_status = {error_sum_r, shifter_empty_flag, tx_fifo_empty_flag,
		break_seen_r, framing_r, parity_r, overrun_r, rx_data_present_flag};
	assign modem_status = {3'h0, cts_sync_r, 3'h0, cts_changed_r};

	// ==========================================================
	// receive idle timer in character times
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			idle_count_r <= 3'h0;
		end else if (rx_char_done_in || !rx_data_present_flag || receive_fifo_flush) begin
			idle_count_r <= 3'h0;
		end else if (rx_char_time_in && (idle_count_r != `UFS_IDLE_CHARS)) begin
			idle_count_r <= idle_count_r + 3'h1;
		end
	end

	// ==========================================================
	// interrupt sources and identity
	assign line_irq = irq_enable_r[`UFS_IEN_LINE] &
		(overrun_r | parity_r | framing_r | break_seen_r);
	assign rx_data_irq = irq_enable_r[`UFS_IEN_RX_DATA] &
		(rx_fifo_count_in >= rx_trigger);
	assign rx_idle_irq = irq_enable_r[`UFS_IEN_RX_DATA] & rx_data_present_flag &
		(rx_fifo_count_in < rx_trigger) & (idle_count_r == `UFS_IDLE_CHARS);
	assign tx_empty_irq = irq_enable_r[`UFS_IEN_TX_EMPTY] & tx_fifo_empty_flag;
	assign modem_irq = irq_enable_r[`UFS_IEN_MODEM] & cts_changed_r;

	always @* begin
		irq_ident_nxt = {3'h0, 1'b1};
		if (line_irq) begin
			irq_ident_nxt = {`UFS_IRQ_LINE, 1'b0};
		end else if (rx_data_irq) begin
			irq_ident_nxt = {`UFS_IRQ_RX_DATA, 1'b0};
		end else if (rx_idle_irq) begin
			irq_ident_nxt = {`UFS_IRQ_RX_IDLE, 1'b0};
		end else if (tx_empty_irq) begin
			irq_ident_nxt = {`UFS_IRQ_TX_EMPTY, 1'b0};
		end else if (modem_irq) begin
			irq_ident_nxt = {`UFS_IRQ_MODEM, 1'b0};
		end
	end

	// ==========================================================
	// read data, registered at the address phase edge
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (haddr_in[7:0])
			`UFS_OFS_CONTROL:      rdata_nxt = {24'h00_0000, control_r};
			`UFS_OFS_IRQ_ENABLE:   rdata_nxt = {26'h000_0000, irq_enable_r};
			`UFS_OFS_LINE_STATUS:  rdata_nxt = {24'h00_0000, line_status};
			`UFS_OFS_MODEM_STATUS: rdata_nxt = {24'h00_0000, modem_status};
			`UFS_OFS_IRQ_IDENT:    rdata_nxt = {28'h000_0000, irq_ident_nxt};
			`UFS_OFS_FIFO_LEVEL:   rdata_nxt = {19'h0_0000, tx_fifo_count_in,
				3'h0, rx_fifo_count_in};
			default:               rdata_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (addr_phase && !hwrite_in) begin
			hrdata_out <= rdata_nxt;
		end
	end

endmodule // ufs_top

/* tb/ufs_checker.sv */
`timescale 1ns/10ps
`include "ufs_consts.vh"
// ==========
// port relations of the handshake, break and flush controls
module ufs_checker (
	input wire logic        clock_in,
	input wire logic        reset_n_in,
	input wire logic        hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic [2:0]  hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic        hready_in,
	input wire logic [4:0]  rx_fifo_count_in,
	input wire logic        clear_to_send_pin_in,
	input wire logic        tx_start_allow_out,
	input wire logic        tx_break_out,
	input wire logic        tx_fifo_flush_out,
	input wire logic        rx_fifo_flush_out,
	input wire logic        request_to_send_out,
	input wire logic        request_to_send_oe_out
);
	logic       wr_ph_r;
	logic [7:0] wr_ofs_r;
	logic [7:0] ctl_r;
	logic [4:0] lvl;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	// shadow of the control word, updated on the same edge as the block's own
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ph_r <= 1'b0;
			wr_ofs_r <= 8'h00;
			ctl_r <= 8'h00;
		end else begin
			if (wr_ph_r && wr_ofs_r == `UFS_OFS_CONTROL)
				ctl_r <= hwdata_in[7:0];
			wr_ph_r <= hsel_in && htrans_in[1] && hready_in && hwrite_in && hsize_in == 3'h2;
			wr_ofs_r <= haddr_in[7:0];
		end
	end
	assign lvl = ctl_r[5] ? (ctl_r[4] ? 5'h0F : 5'h0D) : (ctl_r[4] ? 5'h0B : 5'h08);
	// ==========
	// properties
	property p_rts_off;
		ctl_r[0] && ctl_r[1] && rx_fifo_count_in >= lvl |=> request_to_send_out != $past(ctl_r[3]);
	endproperty
	property p_rts_on;
		ctl_r[0] && ctl_r[1] && rx_fifo_count_in < lvl |=> request_to_send_out == $past(ctl_r[3]);
	endproperty
	property p_gate;
		(ctl_r[0] && ctl_r[2] && clear_to_send_pin_in != ctl_r[3])[*4] |-> !tx_start_allow_out;
	endproperty
	property p_manual;
		ctl_r[0] && !ctl_r[1] |=> request_to_send_out == $past(ctl_r[6]);
	endproperty
	property p_oe;
		1'b1 |=> request_to_send_oe_out == $past(ctl_r[0]);
	endproperty
	property p_brk;
		ctl_r[7] |=> tx_break_out;
	endproperty
	property p_unbrk;
		!ctl_r[7] |=> !tx_break_out;
	endproperty
	property p_flush;
		wr_ph_r && wr_ofs_r == `UFS_OFS_FIFO_FLUSH |=> tx_fifo_flush_out == $past(hwdata_in[0])
			&& rx_fifo_flush_out == $past(hwdata_in[1]);
	endproperty
	a_rts_off: assert property (p_rts_off) else $error("request line not dropped at level");
	a_rts_on: assert property (p_rts_on) else $error("request line not raised below level");
	a_gate: assert property (p_gate) else $error("start allowed with clear inactive");
	a_manual: assert property (p_manual) else $error("manual request value not driven");
	a_oe: assert property (p_oe) else $error("request enable not four-wire");
	a_brk: assert property (p_brk) else $error("break not driven");
	a_unbrk: assert property (p_unbrk) else $error("break not released");
	a_flush: assert property (p_flush) else $error("flush pulse wrong");
	c_rts_off: cover property (ctl_r[1] && rx_fifo_count_in >= lvl);
	c_gate: cover property (ctl_r[2] && !tx_start_allow_out);
	c_brk: cover property (tx_break_out);
endmodule // ufs_checker

bind ufs_top ufs_checker u_ufs_checker (.clock_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in,
	.hwrite_in, .hsize_in, .hwdata_in, .hready_in, .rx_fifo_count_in, .clear_to_send_pin_in,
	.tx_start_allow_out, .tx_break_out, .tx_fifo_flush_out, .rx_fifo_flush_out,
	.request_to_send_out, .request_to_send_oe_out);

/* tb/ufs_remote.sv */
`timescale 1ns/10ps
// ==========
// remote serial peer: grants our transmitter through its clear output
module ufs_remote #(
	parameter int LAG = 1
) (
	input  wire logic clock_in,
	input  wire logic reset_n_in,
	input  wire logic rts_pin_in,
	input  wire logic polarity_in,
	input  wire logic grant_in,
	output wire logic cts_pin_out,
	output wire logic rts_active_out
);
	logic [7:0] grant_r;
	// slow peers answer late; LAG sets how many cycles
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			grant_r <= 8'h00;
		else
			grant_r <= {grant_r[6:0], grant_in};
	end
	assign cts_pin_out = grant_r[LAG-1] ? polarity_in : !polarity_in;
	assign rts_active_out = rts_pin_in == polarity_in;
endmodule // ufs_remote

/* tb/testbench.sv */
`timescale 1ns/10ps
`include "ufs_consts.vh"
module testbench;
	logic        clock_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        hsel = 1'b0, hwrite = 1'b0, busy = 1'b0, done = 1'b0, perr = 1'b0;
	logic        ferr = 1'b0, brk = 1'b0, ctime = 1'b0, pol = 1'b0, grant = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [4:0]  rxc = 5'h00, txc = 5'h00;
	wire         hready, hresp, allow, tbrk, txfl, rxfl, rts, rts_oe, cts, rts_ok;
	wire  [31:0] hrdata;
	int          n_mismatch = 0, n_checks = 0;
	int          lv[4] = '{8, 11, 13, 15};
	int          tr[4] = '{1, 4, 8, 14};
	always #2 clock_in = ~clock_in;
	initial begin
		repeat (2) @(posedge clock_in);
		reset_n_in <= 1'b1;
	end
	ufs_top u_ufs_top (.clock_in, .reset_n_in, .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
		.rx_fifo_count_in(rxc), .tx_fifo_count_in(txc), .tx_shifter_busy_in(busy),
		.rx_char_done_in(done), .rx_parity_err_in(perr), .rx_frame_err_in(ferr),
		.rx_break_in(brk), .rx_char_time_in(ctime), .tx_start_allow_out(allow),
		.tx_break_out(tbrk), .tx_fifo_flush_out(txfl), .rx_fifo_flush_out(rxfl),
		.clear_to_send_pin_in(cts), .request_to_send_out(rts), .request_to_send_oe_out(rts_oe));
	ufs_remote u_ufs_remote (.clock_in, .reset_n_in, .rts_pin_in(rts), .polarity_in(pol),
		.grant_in(grant), .cts_pin_out(cts), .rts_active_out(rts_ok));
	// ==========
	// shared tasks
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (hready !== 1'b1 && n < 16);
		if (hready !== 1'b1) begin
			n_mismatch++;
			report_and_stop;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e, input string s);
		bus(1'b0, a, 32'h0);
		chk(s, e, q);
	endtask
	task ev(input logic [4:0] m);
		{ctime, brk, ferr, perr, done} <= m;
		@(posedge clock_in);
		{ctime, brk, ferr, perr, done} <= 5'h00;
		@(posedge clock_in);
	endtask
	// ==========
	// scenarios
	task t_reset;
		rc(`UFS_OFS_CONTROL, 32'h0, "control");
		rc(`UFS_OFS_IRQ_ENABLE, 32'h0, "irq enable");
		rc(8'h1C, 32'h0, "unmapped");
		rc(`UFS_OFS_LINE_STATUS, 32'h60, "line status");
		rc(`UFS_OFS_IRQ_IDENT, 32'h1, "ident idle");
		rc(`UFS_OFS_MODEM_STATUS, 32'h10, "modem after reset");
		chk("response okay", 0, hresp);
		$display("done: reset values");
	endtask
	task t_req;
		for (int i = 0; i < 4; i++) begin
			wr(`UFS_OFS_CONTROL, {26'h0, i[1:0], i[0], 3'h3});
			pol <= i[0];
			rxc <= 5'(lv[i] - 1);
			tick(2);
			chk("rts below level", 1, rts_ok);
			rxc <= 5'(lv[i]);
			tick(2);
			chk("rts at level", 0, rts_ok);
			chk("rts enable on", 1, rts_oe);
		end
		rxc <= 5'h0E;
		tick(2);
		chk("rts reasserted", 1, rts_ok);
		wr(`UFS_OFS_CONTROL, 32'h41);
		tick(2);
		chk("manual rts", 1, rts);
		wr(`UFS_OFS_CONTROL, 32'h0);
		tick(2);
		chk("rts enable", 0, rts_oe);
		$display("done: auto request");
	endtask
	task t_cts;
		pol <= 1'b0;
		wr(`UFS_OFS_CONTROL, 32'h05);
		tick(6);
		bus(1'b0, `UFS_OFS_MODEM_STATUS, 32'h0);
		chk("gate closed", 0, allow);
		grant <= 1'b1;
		tick(6);
		chk("gate open", 1, allow);
		rc(`UFS_OFS_MODEM_STATUS, 32'h01, "modem change");
		rc(`UFS_OFS_MODEM_STATUS, 32'h00, "modem cleared");
		wr(`UFS_OFS_CONTROL, 32'h01);
		grant <= 1'b0;
		tick(6);
		chk("no gate", 1, allow);
		rc(`UFS_OFS_MODEM_STATUS, 32'h11, "modem high");
		$display("done: clear gate");
	endtask
	task t_brk;
		wr(`UFS_OFS_CONTROL, 32'h80);
		tick(2);
		chk("break", 1, tbrk);
		chk("break stops", 0, allow);
		wr(`UFS_OFS_CONTROL, 32'h0);
		tick(2);
		chk("break off", 0, tbrk);
		chk("resume", 1, allow);
		$display("done: break");
	endtask
	task t_flush;
		for (int i = 1; i < 4; i++) begin
			wr(`UFS_OFS_IRQ_ENABLE, 32'h31);
			wr(`UFS_OFS_FIFO_FLUSH, 32'(i));
			tick(1);
			chk("tx flush pulse", i[0], txfl);
			chk("rx flush pulse", i[1], rxfl);
			rc(`UFS_OFS_IRQ_ENABLE, 32'h01, "trigger reset");
			chk("flush pulse ends", 0, txfl | rxfl);
		end
		$display("done: flush");
	endtask
	task t_lsr;
		busy <= 1'b1;
		txc <= 5'h03;
		rxc <= 5'h02;
		ev(5'h03);
		rc(`UFS_OFS_LINE_STATUS, 32'h85, "parity");
		rc(`UFS_OFS_LINE_STATUS, 32'h01, "cleared");
		ev(5'h05);
		rc(`UFS_OFS_LINE_STATUS, 32'h89, "framing");
		ev(5'h09);
		rc(`UFS_OFS_LINE_STATUS, 32'h91, "break seen");
		rxc <= 5'h10;
		ev(5'h01);
		rc(`UFS_OFS_LINE_STATUS, 32'h03, "overrun");
		rc(`UFS_OFS_LINE_STATUS, 32'h01, "cleared");
		busy <= 1'b0;
		txc <= 5'h00;
		rxc <= 5'h00;
		tick(1);
		rc(`UFS_OFS_LINE_STATUS, 32'h60, "empty flags");
		$display("done: line status");
	endtask
	task t_irq;
		rxc <= 5'h02;
		wr(`UFS_OFS_IRQ_ENABLE, 32'h05);
		ev(5'h03);
		rc(`UFS_OFS_IRQ_IDENT, 32'h06, "line first");
		rc(`UFS_OFS_LINE_STATUS, 32'hE5, "line status");
		rc(`UFS_OFS_IRQ_IDENT, 32'h04, "rx data");
		rxc <= 5'h00;
		grant <= 1'b1;
		wr(`UFS_OFS_IRQ_ENABLE, 32'h0A);
		tick(6);
		rc(`UFS_OFS_IRQ_IDENT, 32'h02, "tx empty");
		txc <= 5'h04;
		rc(`UFS_OFS_IRQ_IDENT, 32'h00, "modem");
		bus(1'b0, `UFS_OFS_MODEM_STATUS, 32'h0);
		rc(`UFS_OFS_IRQ_IDENT, 32'h01, "none");
		wr(`UFS_OFS_IRQ_ENABLE, 32'h11);
		rxc <= 5'h03;
		rc(`UFS_OFS_IRQ_IDENT, 32'h01, "below trigger");
		rxc <= 5'h04;
		rc(`UFS_OFS_IRQ_IDENT, 32'h04, "trigger 4");
		rxc <= 5'h01;
		repeat (4) ev(5'h10);
		rc(`UFS_OFS_IRQ_IDENT, 32'h0C, "timeout");
		// idle count stays full while the fifo keeps data and nothing arrives
		for (int k = 2; k < 4; k++) begin
			wr(`UFS_OFS_IRQ_ENABLE, {26'h0, k[1:0], 4'h1});
			rxc <= 5'(tr[k] - 1);
			rc(`UFS_OFS_IRQ_IDENT, 32'h0C, "idle below trigger");
			rxc <= 5'(tr[k]);
			rc(`UFS_OFS_IRQ_IDENT, 32'h04, "at trigger");
		end
		rxc <= 5'h05;
		txc <= 5'h09;
		rc(`UFS_OFS_FIFO_LEVEL, 32'h0905, "levels");
		$display("done: interrupt identity");
	endtask
	initial begin
		tick(3);
		t_reset;
		t_req;
		t_cts;
		t_brk;
		t_flush;
		t_lsr;
		t_irq;
		report_and_stop;
	end
endmodule // testbench
